// ==== hdl/qgp_pkg.sv ====
// Package of register addresses, reset values and access carriers for the quad GPIO ports.
package qgp_pkg;

  // ----------------------------------------------------------------
  // Special function register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_ZERO_DATA      = 8'h80;
  localparam logic [7:0] ADDR_PORT_ONE_DATA       = 8'h90;
  localparam logic [7:0] ADDR_PORT_TWO_DATA       = 8'hA0;
  localparam logic [7:0] ADDR_PORT_THREE_DATA     = 8'hB0;
  localparam logic [7:0] ADDR_PORT_ZERO_PULLDOWN  = 8'hE3;
  localparam logic [7:0] ADDR_PORT_ONE_PULLDOWN   = 8'hE4;
  localparam logic [7:0] ADDR_PORT_TWO_PULLDOWN   = 8'hE5;
  localparam logic [7:0] ADDR_PORT_THREE_PULLDOWN = 8'hE6;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam int         NUM_PORTS      = 4;
  localparam int         PORT_W         = 8;
  localparam logic [7:0] DATA_RESET     = 8'hFF;
  localparam logic [7:0] PULLDOWN_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE      = 8'h00;

  // ----------------------------------------------------------------
  // Register access from the core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       rmw;
    logic [7:0] addr;
    logic [7:0] wdata;
  } qgp_reg_req_t;

  typedef struct packed {
    logic       hit;
    logic [7:0] rdata;
  } qgp_reg_rsp_t;

endpackage

// ==== hdl/qgp_sync.sv ====
// Two-flop synchroniser for a bus of pin levels.
`timescale 1ns/1ps
`default_nettype none
module qgp_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------
  // Reset to all ones matches an undriven port held at its idle high level.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/qgp_top.sv ====
// Four 8-bit general purpose I/O ports with data and pull-down registers.
// Operation
// R1 - Four port data registers, reset all ones
// R2 - Read returns data register or pin levels
// R3 - Read-modify-write reads come from data register
// R4 - Bit writes keep other bits from register
// R5 - Other reads return synchronised pin levels
// R6 - Every pin usable as input or output
// R7 - Pull-down enables for ports zero, one
// R8 - Pull-down enables for ports two, three
// R9 - Writes update register next edge, drive follows
`timescale 1ns/1ps
`default_nettype none
module qgp_top #(
  parameter int PORT_W = qgp_pkg::PORT_W
) (
  input  wire logic                        CORE_CLK,
  input  wire logic                        RST_B,
  input  wire qgp_pkg::qgp_reg_req_t       REG_REQ,
  output var  qgp_pkg::qgp_reg_rsp_t       REG_RSP,
  input  wire logic [PORT_W-1:0]           PORT_ZERO_IN,
  input  wire logic [PORT_W-1:0]           PORT_ONE_IN,
  input  wire logic [PORT_W-1:0]           PORT_TWO_IN,
  input  wire logic [PORT_W-1:0]           PORT_THREE_IN,
  output var  logic [PORT_W-1:0]           PORT_ZERO_OUT,
  output var  logic [PORT_W-1:0]           PORT_ONE_OUT,
  output var  logic [PORT_W-1:0]           PORT_TWO_OUT,
  output var  logic [PORT_W-1:0]           PORT_THREE_OUT,
  output var  logic [PORT_W-1:0]           PORT_ZERO_OE,
  output var  logic [PORT_W-1:0]           PORT_ONE_OE,
  output var  logic [PORT_W-1:0]           PORT_TWO_OE,
  output var  logic [PORT_W-1:0]           PORT_THREE_OE,
  output var  logic [PORT_W-1:0]           PORT_ZERO_PULLDOWN_EN,
  output var  logic [PORT_W-1:0]           PORT_ONE_PULLDOWN_EN,
  output var  logic [PORT_W-1:0]           PORT_TWO_PULLDOWN_EN,
  output var  logic [PORT_W-1:0]           PORT_THREE_PULLDOWN_EN
);

  localparam int NP = qgp_pkg::NUM_PORTS;

  logic [PORT_W-1:0] data_q     [NP];
  logic [PORT_W-1:0] pulldown_q [NP];
  logic [PORT_W-1:0] pin_raw    [NP];
  logic [PORT_W-1:0] pin_sync   [NP];
  // Decoded target of the current request; NP when the address misses.
  int                data_idx;
  int                pulldown_idx;
  logic              data_sel;
  logic              pulldown_sel;
  logic [NP-1:0]     data_wr;
  logic [NP-1:0]     pulldown_wr;
  logic [PORT_W-1:0] rdata_d;
  logic              hit_d;
  logic [PORT_W-1:0] rdata_q;
  logic              hit_q;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  // Returns the port index of a data register address, or NP when none.
  function automatic int data_index(input logic [7:0] a);
    int idx;
    idx = NP;
    if (a == qgp_pkg::ADDR_PORT_ZERO_DATA) begin
      idx = 0;
    end else if (a == qgp_pkg::ADDR_PORT_ONE_DATA) begin
      idx = 1;
    end else if (a == qgp_pkg::ADDR_PORT_TWO_DATA) begin
      idx = 2;
    end else if (a == qgp_pkg::ADDR_PORT_THREE_DATA) begin
      idx = 3;
    end
    return idx;
  endfunction

  // Returns the port index of a pull-down register address, or NP when none.
  function automatic int pulldown_index(input logic [7:0] a);
    int idx;
    idx = NP;
    if (a == qgp_pkg::ADDR_PORT_ZERO_PULLDOWN) begin
      idx = 0;
    end else if (a == qgp_pkg::ADDR_PORT_ONE_PULLDOWN) begin
      idx = 1;
    end else if (a == qgp_pkg::ADDR_PORT_TWO_PULLDOWN) begin
      idx = 2;
    end else if (a == qgp_pkg::ADDR_PORT_THREE_PULLDOWN) begin
      idx = 3;
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw[0] = PORT_ZERO_IN;
  assign pin_raw[1] = PORT_ONE_IN;
  assign pin_raw[2] = PORT_TWO_IN;
  assign pin_raw[3] = PORT_THREE_IN;

  // Pin levels reach the read mux two edges after they settle.
  for (genvar g = 0; g < NP; g++) begin : g_sync
    qgp_sync #(
      .W (PORT_W)
    ) u_sync (
      .clk      (CORE_CLK),
      .rst_b    (RST_B),
      .async_in (pin_raw[g]),
      .sync_out (pin_sync[g])
    );
  end

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // The address is decoded once per cycle and shared by the write strobes and
  // the read mux, so both paths always agree on the target register.
  always_comb begin
    data_idx     = data_index(REG_REQ.addr);
    pulldown_idx = pulldown_index(REG_REQ.addr);
    data_sel     = data_idx < NP;
    pulldown_sel = pulldown_idx < NP;
  end

  // An unmapped address raises no strobe, so its write is dropped.
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      data_wr[i]     = REG_REQ.wr && data_sel && data_idx == i;
      pulldown_wr[i] = REG_REQ.wr && pulldown_sel && pulldown_idx == i;
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  // The core presents the full modified byte on a write; for bit instructions it
  // built that byte from the register value returned on the preceding rmw read.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < NP; i++) begin
        data_q[i] <= qgp_pkg::DATA_RESET[PORT_W-1:0]; // [R1]
      end
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (data_wr[i]) begin
          data_q[i] <= REG_REQ.wdata[PORT_W-1:0]; // [R9] [R4]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pull-down registers
  // ----------------------------------------------------------------
  // Pull-down enables come out of reset cleared, leaving every pin floating.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < NP; i++) begin
        pulldown_q[i] <= qgp_pkg::PULLDOWN_RESET[PORT_W-1:0]; // [R7] [R8]
      end
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (pulldown_wr[i]) begin
          pulldown_q[i] <= REG_REQ.wdata[PORT_W-1:0]; // [R7] [R8]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Bit instructions read with the rmw class, so the bits they keep come from the register.
  always_comb begin
    rdata_d = qgp_pkg::READ_IDLE[PORT_W-1:0];
    hit_d   = 1'b0;
    if (REG_REQ.rd && data_sel) begin
      hit_d = 1'b1;
      if (REG_REQ.rmw) begin
        rdata_d = data_q[data_idx]; // [R2] [R3] [R4]
      end else begin
        rdata_d = pin_sync[data_idx]; // [R2] [R5]
      end
    end else if (REG_REQ.rd && pulldown_sel) begin
      hit_d   = 1'b1;
      rdata_d = pulldown_q[pulldown_idx];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_q <= qgp_pkg::READ_IDLE[PORT_W-1:0];
      hit_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
    end
  end

  // The response is registered, so a read is answered one edge after it is taken.
  assign REG_RSP = '{hit: hit_q, rdata: 8'(rdata_q)};

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Quasi-bidirectional: a zero is driven low, a one releases the pin so that
  // it can serve as an input read through the pin path.
  assign PORT_ZERO_OUT  = data_q[0]; // [R9]
  assign PORT_ONE_OUT   = data_q[1];
  assign PORT_TWO_OUT   = data_q[2];
  assign PORT_THREE_OUT = data_q[3];
  assign PORT_ZERO_OE   = ~data_q[0]; // [R6]
  assign PORT_ONE_OE    = ~data_q[1]; // [R6]
  assign PORT_TWO_OE    = ~data_q[2]; // [R6]
  assign PORT_THREE_OE  = ~data_q[3]; // [R6]

  // Pull-down enables go straight to the pads; a pin driven low wins over them.
  assign PORT_ZERO_PULLDOWN_EN  = pulldown_q[0]; // [R7]
  assign PORT_ONE_PULLDOWN_EN   = pulldown_q[1]; // [R7]
  assign PORT_TWO_PULLDOWN_EN   = pulldown_q[2]; // [R8]
  assign PORT_THREE_PULLDOWN_EN = pulldown_q[3]; // [R8]

endmodule
`default_nettype wire

// ==== dv/qgp_board_model.sv ====
// Board-side model of the pin levels seen by the four ports.
`timescale 1ns/1ps
`default_nettype none
module qgp_board_model (
  input  wire logic [3:0][7:0] out_v,
  input  wire logic [3:0][7:0] oe_v,
  input  wire logic [3:0][7:0] pd_v,
  input  wire logic [3:0][7:0] ext_v,
  output var  logic [3:0][7:0] pin_v
);
  // A driven pin wins, then an enabled pull-down, then the board's own level.
  always_comb pin_v = (oe_v & out_v) | (~oe_v & ~pd_v & ext_v);
endmodule
`default_nettype wire

// ==== dv/qgp_top_assertions.sv ====
// Checker of port zero and pull-down behaviour at the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module qgp_top_chk #(
  parameter int PORT_W = 8
) (
  input wire logic                  CORE_CLK,
  input wire logic                  RST_B,
  input wire qgp_pkg::qgp_reg_req_t REG_REQ,
  input wire qgp_pkg::qgp_reg_rsp_t REG_RSP,
  input wire logic [PORT_W-1:0]     PORT_ZERO_IN,
  input wire logic [PORT_W-1:0]     PORT_ZERO_OUT,
  input wire logic [PORT_W-1:0]     PORT_ZERO_OE,
  input wire logic [PORT_W-1:0]     PORT_ZERO_PULLDOWN_EN,
  input wire logic [PORT_W-1:0]     PORT_TWO_PULLDOWN_EN
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  wire logic mapped = REG_REQ.addr inside {8'h80, 8'h90, 8'hA0, 8'hB0, [8'hE3:8'hE6]};
  wire logic hit0 = REG_REQ.addr == qgp_pkg::ADDR_PORT_ZERO_DATA;
  wire logic w0 = REG_REQ.wr && hit0;
  wire logic r0 = REG_REQ.rd && hit0;
  sequence pins_steady; $stable(PORT_ZERO_IN) [*3]; endsequence
  sequence pin_read0; pins_steady ##0 (r0 && !REG_REQ.rmw); endsequence
  data_write_a: assert property (w0 |=> PORT_ZERO_OUT == $past(REG_REQ.wdata))
    else $error("port zero data not written");
  data_hold_a: assert property (!w0 |=> $stable(PORT_ZERO_OUT))
    else $error("port zero data changed without write");
  drive_follow_a: assert property (PORT_ZERO_OE == ~PORT_ZERO_OUT)
    else $error("port zero drive differs from data");
  rmw_read_a: assert property (r0 && REG_REQ.rmw |=>
    REG_RSP.hit && REG_RSP.rdata == $past(PORT_ZERO_OUT)) else $error("rmw read wrong");
  pin_read_a: assert property (pin_read0 |=> REG_RSP.rdata == $past(PORT_ZERO_IN))
    else $error("pin read wrong");
  pd_zero_a: assert property (REG_REQ.wr && REG_REQ.addr == 8'hE3 |=>
    PORT_ZERO_PULLDOWN_EN == $past(REG_REQ.wdata)) else $error("pull-down zero wrong");
  pd_two_a: assert property (REG_REQ.wr && REG_REQ.addr == 8'hE5 |=>
    PORT_TWO_PULLDOWN_EN == $past(REG_REQ.wdata)) else $error("pull-down two wrong");
  read_hit_a: assert property (1'b1 |=> REG_RSP.hit == $past(REG_REQ.rd && mapped))
    else $error("read hit wrong");
  idle_zero_a: assert property (!REG_RSP.hit |-> REG_RSP.rdata == 8'h00)
    else $error("idle read data not zero");
endmodule
bind qgp_top qgp_top_chk #(.PORT_W(PORT_W)) qgp_top_chk_inst (.CORE_CLK(CORE_CLK),
  .RST_B(RST_B), .REG_REQ(REG_REQ), .REG_RSP(REG_RSP), .PORT_ZERO_IN(PORT_ZERO_IN),
  .PORT_ZERO_OUT(PORT_ZERO_OUT), .PORT_ZERO_OE(PORT_ZERO_OE),
  .PORT_ZERO_PULLDOWN_EN(PORT_ZERO_PULLDOWN_EN), .PORT_TWO_PULLDOWN_EN(PORT_TWO_PULLDOWN_EN));
`default_nettype wire

// ==== dv/test_quad_byte_gpio_ports.sv ====
// Self-checking testbench of the four GPIO ports.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module test_quad_byte_gpio_ports;
  logic                  clk;
  logic                  rst_b;
  logic                  rdq = 1'b0;
  qgp_pkg::qgp_reg_req_t req;
  qgp_pkg::qgp_reg_rsp_t rsp, e;
  qgp_pkg::qgp_reg_rsp_t q[$];
  wire logic [3:0][7:0]  po, pe, pp, pi;
  logic [3:0][7:0]       ext, dq, pq;
  logic [7:0]            a;
  logic [7:0]            adr [9] = '{8'h80, 8'h90, 8'hA0, 8'hB0, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'h81};
  int                    errors = 0;
  int                    checks_done = 0;
  qgp_top qgp_top_inst (.CORE_CLK(clk), .RST_B(rst_b), .REG_REQ(req), .REG_RSP(rsp),
    .PORT_ZERO_IN(pi[0]), .PORT_ONE_IN(pi[1]), .PORT_TWO_IN(pi[2]), .PORT_THREE_IN(pi[3]),
    .PORT_ZERO_OUT(po[0]), .PORT_ONE_OUT(po[1]), .PORT_TWO_OUT(po[2]), .PORT_THREE_OUT(po[3]),
    .PORT_ZERO_OE(pe[0]), .PORT_ONE_OE(pe[1]), .PORT_TWO_OE(pe[2]), .PORT_THREE_OE(pe[3]),
    .PORT_ZERO_PULLDOWN_EN(pp[0]), .PORT_ONE_PULLDOWN_EN(pp[1]),
    .PORT_TWO_PULLDOWN_EN(pp[2]), .PORT_THREE_PULLDOWN_EN(pp[3]));
  qgp_board_model board_inst (.out_v(po), .oe_v(pe), .pd_v(pp), .ext_v(ext), .pin_v(pi));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // One request per edge; the expected answer is computed from the model before it moves.
  task automatic acc(input logic w, input logic r, input logic m, input logic [7:0] ad,
                     input logic [7:0] d);
    logic       h;
    logic [7:0] v;
    logic [1:0] i;
    h = 1'b1;
    i = (ad[7:6] == 2'b11) ? ad[1:0] + 2'd1 : ad[5:4];
    if (ad inside {8'h80, 8'h90, 8'hA0, 8'hB0}) v = m ? dq[i] : dq[i] & ~pq[i] & ext[i];
    else if (ad inside {[8'hE3:8'hE6]}) v = pq[i];
    else begin
      h = 1'b0;
      v = 8'h00;
    end
    if (r) q.push_back({h, v});
    @(posedge clk);
    req <= {w, r, m, ad, d};
    if (w && h && ad[7:6] == 2'b11) pq[i] = d;
    else if (w && h) dq[i] = d;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rdq) begin
      e = q.pop_front();
      `CHK(rsp, e)
    end
    rdq <= req.rd;
  end
  initial begin
    void'($urandom(83812));
    rst_b = 1'b0;
    req = '0;
    ext = '0;
    dq = {4{8'hFF}};
    pq = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    foreach (adr[k]) acc(1'b0, 1'b1, 1'b1, adr[k], 8'h00);
    repeat (300) begin
      acc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      ext <= $urandom;
      a = adr[$urandom % 9];
      acc(1'b1, 1'($urandom), 1'b1, a, 8'($urandom));
      acc(1'b0, 1'b1, 1'b1, a, 8'h00);
      repeat (3) acc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      acc(1'b0, 1'b1, 1'b0, adr[$urandom % 9], 8'h00);
      for (int p = 0; p < 4; p++) `CHK({po[p], pe[p], pp[p]}, {dq[p], ~dq[p], pq[p]})
    end
    acc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(q.size(), 0)
    // A reset in mid-run must bring every register back to its reset value.
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    dq = {4{8'hFF}};
    pq = '0;
    rst_b <= 1'b1;
    foreach (adr[k]) acc(1'b0, 1'b1, 1'b1, adr[k], 8'h00);
    for (int p = 0; p < 4; p++) `CHK({po[p], pe[p], pp[p]}, {dq[p], ~dq[p], pq[p]})
    acc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(q.size(), 0)
    complete_run();
  end
endmodule
`default_nettype wire
